// File: hw/trbg_debias.sv
// pairs raw bits: 01 -> 0, 10 -> 1, equal pairs dropped; bypassed when off
module trbg_debias
	import trbg_pkg::*;
(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // sync reset, active low
	input wire logic flush_i, // drop a half pair
	input wire logic enable_i, // bias correction on
	input wire logic raw_bit_i, // raw noise bit
	input wire logic raw_vld_i, // raw bit strobe
	output logic out_bit_o, // corrected bit
	output logic out_vld_o // corrected bit strobe
);
	trbg_pair_t pair_ff;
	logic first_ff;

	// pair tracker
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || flush_i || !enable_i) begin
			pair_ff <= TRBG_PAIR_FIRST;
			first_ff <= 1'b0;
		end else if (raw_vld_i) begin
			case (pair_ff)
				TRBG_PAIR_FIRST: begin
					first_ff <= raw_bit_i;
					pair_ff <= TRBG_PAIR_SECOND;
				end
				TRBG_PAIR_SECOND: begin
					pair_ff <= TRBG_PAIR_FIRST;
				end
				default: begin
					pair_ff <= TRBG_PAIR_FIRST;
				end
			endcase
		end
	end

	// output selection
	always_comb begin
		if (!enable_i) begin
			out_bit_o = raw_bit_i;
			out_vld_o = raw_vld_i;
		end else begin
			out_bit_o = first_ff;
			out_vld_o = raw_vld_i && (pair_ff == TRBG_PAIR_SECOND) && (first_ff != raw_bit_i);
		end
	end
endmodule : trbg_debias

// File: hw/trbg_pkg.sv
package trbg_pkg;
	// register byte offsets
	localparam logic [11:0] TRBG_OFS_START = 12'h000;
	localparam logic [11:0] TRBG_OFS_STOP = 12'h004;
	localparam logic [11:0] TRBG_OFS_READY = 12'h100;
	localparam logic [11:0] TRBG_OFS_SHORTS = 12'h200;
	localparam logic [11:0] TRBG_OFS_INTSET = 12'h304;
	localparam logic [11:0] TRBG_OFS_INTCLR = 12'h308;
	localparam logic [11:0] TRBG_OFS_CONFIG = 12'h504;
	localparam logic [11:0] TRBG_OFS_VALUE = 12'h508;
	localparam logic [11:0] TRBG_OFS_RUNSTAT = 12'h50c;
	// field positions
	localparam int TRBG_BIT_TRIG = 0;
	localparam int TRBG_BIT_FLAG = 0;
	localparam int TRBG_BIT_SHORT = 0;
	localparam int TRBG_BIT_IRQ = 0;
	localparam int TRBG_BIT_BIAS = 0;
	localparam int TRBG_BIT_RUN = 0;
	localparam int TRBG_BYTE_W = 8;
	localparam logic [2:0] TRBG_LAST_BIT = 3'h7;
	localparam logic [1:0] TRBG_RESP_OKAY = 2'h0;
	localparam logic [1:0] TRBG_RESP_SLVERR = 2'h2;
	localparam logic [7:0] TRBG_VALUE_RST = 8'h00;
	typedef enum logic {TRBG_PAIR_FIRST, TRBG_PAIR_SECOND} trbg_pair_t;
endpackage : trbg_pkg

// File: hw/trbg_top.sv
// Notes on behaviour
// - start task begins generation; stop task ends it
// - runs continuously once started unless the ready-halt shortcut is on; each finished byte goes to result register unless it finishes in the stop cycle
// - one value-ready event for every byte written to the result register
// - with correction on, raw bits pass a bias removal step first
// - bits shift into an eight-bit register, copied whole to the result
// - a configuration bit enables bias correction; slower but uniform
// - time per byte depends on the data; no fixed latency
// - no seed input and no seed loading needed
// - with ready-halt shortcut on, each ready event triggers stop
// - ready flag reads 1 when generated; writing 0 clears it
// - write 1 to set bit enables irq; 1 to clear bit disables
module trbg_top
	import trbg_pkg::*;
(
	input wire logic clk_sys_i, // system clock, 25 MHz
	input wire logic rst_n_i, // sync reset, active low
	input wire logic noise_random_source_bit_i, // raw noise bit
	input wire logic noise_random_source_vld_i, // raw bit strobe
	input wire logic [11:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [11:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	output logic irq_o // value-ready interrupt, level
);
	logic running_ff;
	logic bias_en_ff;
	logic shortcut_ff;
	logic irq_en_ff;
	logic value_ready_flag_ff;
	logic [7:0] shift_ff;
	logic [2:0] count_ff;
	logic [7:0] value_ff;
	logic aw_hold_ff;
	logic w_hold_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic irq_ff;
	logic nxt_running;
	logic wr_fire;
	logic byte_done;
	logic start_trig;
	logic stop_trig;
	logic cor_bit;
	logic cor_vld;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;
	logic nxt_aw_hold;
	logic nxt_w_hold;
	logic nxt_bvalid;
	logic nxt_rvalid;
	logic sel_start;
	logic sel_stop;
	logic sel_flag;
	logic sel_short;
	logic sel_iset;
	logic sel_iclr;
	logic sel_cfg;
	logic byte_keep;
	logic flush_pair;
	logic raw_vld_run;

	// true when offset maps to a register
	function automatic logic trbg_mapped(input logic [11:0] a);
		case (a)
			TRBG_OFS_START, TRBG_OFS_STOP, TRBG_OFS_READY, TRBG_OFS_SHORTS,
			TRBG_OFS_INTSET, TRBG_OFS_INTCLR, TRBG_OFS_CONFIG, TRBG_OFS_VALUE,
			TRBG_OFS_RUNSTAT: trbg_mapped = 1'b1;
			default: trbg_mapped = 1'b0;
		endcase
	endfunction : trbg_mapped

	// true when a write lands on the given register
	function automatic logic trbg_wr_at(input logic [11:0] a, input logic [11:0] ofs);
		trbg_wr_at = (a == ofs);
	endfunction : trbg_wr_at

	// next write handshake state; the ready outputs are registered from it
	assign nxt_aw_hold = (s_axi_awvalid && s_axi_awready) || (aw_hold_ff && !wr_fire);
	assign nxt_w_hold = (s_axi_wvalid && s_axi_wready) || (w_hold_ff && !wr_fire);
	assign nxt_bvalid = wr_fire || (s_axi_bvalid && !s_axi_bready);

	// write address latch
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			aw_hold_ff <= 1'b0;
			awaddr_ff <= 12'h000;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_ff <= s_axi_awaddr;
			end
		end
	end

	// write data latch, taken before or after the address
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			w_hold_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			w_hold_ff <= nxt_w_hold;
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	// write lands once address and data are both held
	assign wr_fire = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	assign wr_hit = wr_fire && wstrb_ff[0];

	// write ready outputs from flops; low in reset, high one edge after
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			// no new write while one is held or its response is pending
			s_axi_awready <= !nxt_aw_hold && !nxt_bvalid;
			s_axi_wready <= !nxt_w_hold && !nxt_bvalid;
		end
	end

	// write response valid, held until the master takes it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid <= 1'b0;
		end else begin
			s_axi_bvalid <= nxt_bvalid;
		end
	end

	// write response code, refused for an unmapped offset
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_bresp <= TRBG_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bresp <= trbg_mapped(awaddr_ff) ? TRBG_RESP_OKAY : TRBG_RESP_SLVERR;
		end
	end

	// decoded write strobes, one per writable register
	assign sel_start = wr_hit && trbg_wr_at(awaddr_ff, TRBG_OFS_START);
	assign sel_stop = wr_hit && trbg_wr_at(awaddr_ff, TRBG_OFS_STOP);
	assign sel_flag = wr_hit && trbg_wr_at(awaddr_ff, TRBG_OFS_READY);
	assign sel_short = wr_hit && trbg_wr_at(awaddr_ff, TRBG_OFS_SHORTS);
	assign sel_iset = wr_hit && trbg_wr_at(awaddr_ff, TRBG_OFS_INTSET);
	assign sel_iclr = wr_hit && trbg_wr_at(awaddr_ff, TRBG_OFS_INTCLR);
	assign sel_cfg = wr_hit && trbg_wr_at(awaddr_ff, TRBG_OFS_CONFIG);

	// task triggers from writes of one
	assign start_trig = sel_start && wdata_ff[TRBG_BIT_TRIG];
	assign stop_trig = sel_stop && wdata_ff[TRBG_BIT_TRIG];

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bias_en_ff <= 1'b0;
		end else if (sel_cfg) begin
			bias_en_ff <= wdata_ff[TRBG_BIT_BIAS];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			shortcut_ff <= 1'b0;
		end else if (sel_short) begin
			shortcut_ff <= wdata_ff[TRBG_BIT_SHORT];
		end
	end

	// set and clear, writes of zero ignored
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_en_ff <= 1'b0;
		end else if (sel_iset && wdata_ff[TRBG_BIT_IRQ]) begin
			irq_en_ff <= 1'b1;
		end else if (sel_iclr && wdata_ff[TRBG_BIT_IRQ]) begin
			irq_en_ff <= 1'b0;
		end
	end

	// pair stage is flushed while stopped and fed only while running
	assign flush_pair = !running_ff;
	assign raw_vld_run = noise_random_source_vld_i && running_ff;

	trbg_debias u_debias (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.flush_i(flush_pair),
		.enable_i(bias_en_ff),
		.raw_bit_i(noise_random_source_bit_i),
		.raw_vld_i(raw_vld_run),
		.out_bit_o(cor_bit),
		.out_vld_o(cor_vld)
	);

	// byte completes only when enough bits arrive
	assign byte_done = running_ff && cor_vld && count_ff == TRBG_LAST_BIT;

	// a byte finishing in the stop cycle is dropped
	assign byte_keep = byte_done && !stop_trig;

	// run state, start wins over stop in the same cycle
	always_comb begin
		nxt_running = running_ff;
		if (stop_trig) begin
			nxt_running = 1'b0;
		end
		if (byte_done && shortcut_ff) begin
			nxt_running = 1'b0;
		end
		if (start_trig) begin
			nxt_running = 1'b1;
		end
	end

	// no seed: run flag is the only state needed to start
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			running_ff <= 1'b0;
		end else begin
			running_ff <= nxt_running;
		end
	end

	// shift register, first bit ends in the top bit
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			shift_ff <= TRBG_VALUE_RST;
		end else if (running_ff && !stop_trig && cor_vld) begin
			shift_ff <= {shift_ff[TRBG_BYTE_W-2:0], cor_bit};
		end
	end

	// bit count, cleared while stopped to drop a partial byte
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			count_ff <= 3'h0;
		end else if (!running_ff || stop_trig) begin
			count_ff <= 3'h0;
		end else if (cor_vld) begin
			count_ff <= count_ff + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			value_ff <= TRBG_VALUE_RST;
		end else if (byte_keep) begin
			value_ff <= {shift_ff[TRBG_BYTE_W-2:0], cor_bit};
		end
	end

	// ready flag, set wins over clear
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			value_ready_flag_ff <= 1'b0;
		end else if (byte_keep) begin
			value_ready_flag_ff <= 1'b1;
		end else if (sel_flag) begin
			value_ready_flag_ff <= wdata_ff[TRBG_BIT_FLAG];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= value_ready_flag_ff && irq_en_ff;
		end
	end
	assign irq_o = irq_ff;

	// read data mux
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = trbg_mapped(s_axi_araddr);
		case (s_axi_araddr)
			TRBG_OFS_READY: rd_word[TRBG_BIT_FLAG] = value_ready_flag_ff;
			TRBG_OFS_SHORTS: rd_word[TRBG_BIT_SHORT] = shortcut_ff;
			TRBG_OFS_INTSET: rd_word[TRBG_BIT_IRQ] = irq_en_ff;
			TRBG_OFS_INTCLR: rd_word[TRBG_BIT_IRQ] = irq_en_ff;
			TRBG_OFS_CONFIG: rd_word[TRBG_BIT_BIAS] = bias_en_ff;
			TRBG_OFS_VALUE: rd_word[TRBG_BYTE_W-1:0] = value_ff;
			TRBG_OFS_RUNSTAT: rd_word[TRBG_BIT_RUN] = running_ff;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// next read valid: set when the address is taken, kept until taken back
	assign nxt_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

	// read ready from a flop; one read under way at a time
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !nxt_rvalid;
		end
	end

	// read valid, held until the master takes it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_rvalid <= nxt_rvalid;
		end
	end

	// read data and response, latched when the address is taken
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= TRBG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? TRBG_RESP_OKAY : TRBG_RESP_SLVERR;
		end
	end
endmodule : trbg_top

// File: verif/trbg_top_asserts.sv
module trbg_top_asserts
	import trbg_pkg::*;
(
	input wire logic clk_sys_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic noise_random_source_vld_i, // bit strobe
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r resp
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic irq_o // irq
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp != TRBG_RESP_OKAY
		|-> s_axi_rdata == 32'h0) else $error("refused read data");
	a_irq_rise_cause: assert property ($rose(irq_o) |->
		$past(noise_random_source_vld_i, 2) || $past(s_axi_wvalid, 2)
		|| $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4)) else $error("irq rose");
	a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(s_axi_wvalid, 2)
		|| $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4)) else $error("irq fell");
	a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && !s_axi_bvalid
		&& !s_axi_rvalid) else $error("outputs after reset");

	c_irq: cover property ($rose(irq_o));
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == TRBG_RESP_SLVERR);
endmodule : trbg_top_asserts

bind trbg_top trbg_top_asserts u_trbg_top_asserts (.clk_sys_i, .rst_n_i,
	.noise_random_source_vld_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);

// File: verif/trbg_top_test.sv
module trbg_top_test
	import trbg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'h0, rst_n_i = 1'h0, nbit = 1'h0, nvld = 1'h0, irq;
	logic aw = 1'h0, w = 1'h0, bready = 1'h0, ar = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, rd_d;
	logic [1:0] bresp, rresp, rd_r;
	int fail_count = 0, checks = 0, cyc = 0;

	always #20 clk_sys_i = ~clk_sys_i;

	trbg_top u_trbg_top (.clk_sys_i, .rst_n_i, .noise_random_source_bit_i(nbit),
		.noise_random_source_vld_i(nvld), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(w), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(ar), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_o(irq));

	task automatic complete_run();
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	// cut a hang short
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// write: release each channel at the edge it is taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_sys_i);
		awaddr <= a;
		wdata <= d;
		aw <= 1'h1;
		w <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge clk_sys_i);
			ta = aw && awready;
			tw = w && wready;
			tb = bvalid;
			@(posedge clk_sys_i);
			if (ta) aw <= 1'h0;
			if (tw) w <= 1'h0;
		end while (!tb);
		bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		logic ta, tr;
		@(posedge clk_sys_i);
		araddr <= a;
		ar <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge clk_sys_i);
			ta = ar && arready;
			tr = rvalid;
			rd_d = rdata;
			rd_r = rresp;
			@(posedge clk_sys_i);
			if (ta) ar <= 1'h0;
		end while (!tr);
		rready <= 1'h0;
	endtask : rd

	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk(n, rd_d, e);
	endtask : rdc

	// look at the level between edges, where it has settled
	task automatic irqc(input logic e);
		@(negedge clk_sys_i);
		chk("irq", 32'(irq), 32'(e));
	endtask : irqc

	// one noise bit; the line shows the inverse between strobes
	task automatic send(input logic b);
		@(posedge clk_sys_i);
		nvld <= 1'h1;
		nbit <= b;
		@(posedge clk_sys_i);
		nvld <= 1'h0;
		nbit <= ~b;
	endtask : send

	task automatic byte8(input logic [7:0] v, input logic pair);
		for (int i = 7; i >= 0; i--) begin
			send(v[i]);
			if (pair) send(~v[i]);
		end
	endtask : byte8

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'h1;
		rdc("value", TRBG_OFS_VALUE, 32'h0);
		rdc("flag", TRBG_OFS_READY, 32'h0);
		wr(TRBG_OFS_START, 32'h1);
		byte8(8'ha5, 1'h0);
		rdc("value", TRBG_OFS_VALUE, 32'ha5);
		rdc("flag", TRBG_OFS_READY, 32'h1);
		irqc(1'h0);
		byte8(8'h3c, 1'h0);
		rdc("value", TRBG_OFS_VALUE, 32'h3c);
		wr(TRBG_OFS_INTSET, 32'h0);
		rdc("irq enable", TRBG_OFS_INTSET, 32'h0);
		wr(TRBG_OFS_INTSET, 32'h1);
		rdc("irq enable", TRBG_OFS_INTCLR, 32'h1);
		irqc(1'h1);
		wr(TRBG_OFS_INTCLR, 32'h0);
		rdc("irq enable", TRBG_OFS_INTSET, 32'h1);
		wr(TRBG_OFS_READY, 32'h0);
		rdc("flag", TRBG_OFS_READY, 32'h0);
		irqc(1'h0);
		wr(TRBG_OFS_INTCLR, 32'h1);
		rdc("irq enable", TRBG_OFS_INTSET, 32'h0);
		send(1'h1);
		send(1'h0);
		send(1'h1);
		wr(TRBG_OFS_STOP, 32'h1);
		rdc("running", TRBG_OFS_RUNSTAT, 32'h0);
		byte8(8'hff, 1'h0);
		rdc("value", TRBG_OFS_VALUE, 32'h3c);
		wr(TRBG_OFS_START, 32'h1);
		byte8(8'h96, 1'h0);
		rdc("value", TRBG_OFS_VALUE, 32'h96);
		wr(TRBG_OFS_CONFIG, 32'h1);
		send(1'h1);
		send(1'h1);
		send(1'h0);
		send(1'h0);
		byte8(8'h5a, 1'h1);
		rdc("value", TRBG_OFS_VALUE, 32'h5a);
		wr(TRBG_OFS_CONFIG, 32'h0);
		wr(TRBG_OFS_SHORTS, 32'h1);
		byte8(8'hc3, 1'h0);
		rdc("running", TRBG_OFS_RUNSTAT, 32'h0);
		byte8(8'h11, 1'h0);
		rdc("value", TRBG_OFS_VALUE, 32'hc3);
		rd(12'hffc);
		chk("resp", 32'(rd_r), 32'(TRBG_RESP_SLVERR));
		chk("data", rd_d, 32'h0);
		complete_run();
	end
endmodule : trbg_top_test
